// ### bulk_port_pkg.sv
// Register map, field positions and reset values of the bulk data port control
`default_nettype none
package bulk_port_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTL_ADDR = 8'hD8;
    localparam logic [31:0] CTL_RESET = 32'h001CF000;
    localparam logic [31:0] CTL_WMASK = 32'hFEDFFF00;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int HOLD_BIT = 8;
    localparam int TS_LE_BIT = 9;
    localparam int ISO_LE_BIT = 10;
    localparam int ASY_LE_BIT = 11;
    localparam int BUSY_POL_BIT = 12;
    localparam int AVAIL_POL_BIT = 13;
    localparam int OEN_POL_BIT = 14;
    localparam int IEN_POL_BIT = 15;
    localparam int ONE_WAY_BIT = 16;
    localparam int WR_ONLY_BIT = 17;
    localparam int PEN_POL_BIT = 18;
    localparam int PERR_POL_BIT = 19;
    localparam int VALID_POL_BIT = 20;
    localparam int OMODE_MSB_BIT = 22;
    localparam int OMODE_LSB_BIT = 23;
    localparam int IMODE_MSB_BIT = 25;
    localparam int IMODE_MID_BIT = 26;
    localparam int IMODE_LSB_BIT = 27;
    localparam int PASS_PAD_BIT = 28;
    localparam int OUT_RST_BIT = 29;
    localparam int IN_RST_BIT = 30;
    localparam int FLOAT_BIT = 31;
    // ------------------------------------------------------------
    // Mode codes and stream kinds
    // ------------------------------------------------------------
    localparam logic [2:0] IMODE_A = 3'h2;
    localparam logic [2:0] IMODE_B = 3'h5;
    localparam logic [1:0] STREAM_TS = 2'h0;
    localparam logic [1:0] STREAM_ISO = 2'h1;
    localparam logic [1:0] STREAM_ASY = 2'h2;
endpackage : bulk_port_pkg
`default_nettype wire

// ### bulk_data_port_control.sv
// Control register and pin-side logic of the bulk data port
`default_nettype none
module bulk_data_port_control (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received stream from the link, towards the port
    input wire logic rx_valid,
    input wire logic [31:0] rx_data,
    input wire logic rx_last,
    input wire logic [1:0] rx_bytes,
    input wire logic [1:0] rx_stream,
    input wire logic avail_raw,
    // Port output data bus
    output logic [31:0] out_data,
    output logic out_data_oe,
    output logic [3:0] out_byte_en,
    // Port input data, towards the link
    input wire logic [31:0] in_data,
    input wire logic in_last,
    input wire logic [1:0] in_bytes,
    input wire logic [1:0] in_stream,
    input wire logic input_enable_pin,
    output logic [31:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    // Link-side status, active high
    input wire logic busy_raw,
    input wire logic pkt_enable_raw,
    input wire logic pkt_error_raw,
    input wire logic valid_raw,
    // Handshake and flag pins
    output logic input_busy,
    output logic output_available,
    output logic output_enable_pin,
    output logic packet_enable_flag,
    output logic packet_error_flag,
    output logic valid_flag,
    // Mode fields for the datapath
    output logic [1:0] output_port_mode,
    output logic [2:0] input_port_mode
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte reversal when little-endian is selected for the stream
    function automatic logic [31:0] order(input logic [31:0] d, input logic le);
        order = le ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    endfunction

    // Byte mask of a final quadlet; byte 0 sits in the high lane
    function automatic logic [3:0] keep(input logic last, input logic [1:0] n);
        unique case ({last, n})
            3'b101: keep = 4'h8;
            3'b110: keep = 4'hC;
            3'b111: keep = 4'hE;
            default: keep = 4'hF;
        endcase
    endfunction

    // Expand a byte mask to a bit mask
    function automatic logic [31:0] lanes(input logic [3:0] m);
        lanes = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    endfunction

    // Little-endian select of a stream kind
    function automatic logic le_of(input logic [31:0] c, input logic [1:0] s);
        unique case (s)
            bulk_port_pkg::STREAM_TS: le_of = c[bulk_port_pkg::TS_LE_BIT];
            bulk_port_pkg::STREAM_ISO: le_of = c[bulk_port_pkg::ISO_LE_BIT];
            bulk_port_pkg::STREAM_ASY: le_of = c[bulk_port_pkg::ASY_LE_BIT];
            default: le_of = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] ctl_q;
    logic [31:0] ctl_d;
    logic hit;
    logic wr_take;
    logic [2:0] imode;
    logic mode_a;
    logic mode_b;

    assign hit = paddr == bulk_port_pkg::CTL_ADDR;
    assign wr_take = psel & penable & pready & pwrite & hit;
    assign imode = {ctl_q[bulk_port_pkg::IMODE_MSB_BIT],
                    ctl_q[bulk_port_pkg::IMODE_MID_BIT],
                    ctl_q[bulk_port_pkg::IMODE_LSB_BIT]};
    assign mode_a = imode == bulk_port_pkg::IMODE_A;
    assign mode_b = imode == bulk_port_pkg::IMODE_B;

    // One wait state, then answer; unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            if (psel & penable & ~pready) begin
                prdata <= hit ? ctl_q : 32'h00000000;
            end
        end
    end

    // Next control value: writable bits only, init bits fall back to zero
    always_comb begin
        ctl_d = ctl_q;
        ctl_d[bulk_port_pkg::OUT_RST_BIT] = 1'b0;
        ctl_d[bulk_port_pkg::IN_RST_BIT] = 1'b0;
        if (wr_take) begin
            ctl_d = pwdata & bulk_port_pkg::CTL_WMASK;
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= bulk_port_pkg::CTL_RESET;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // Mode fields for the datapath
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_port_mode <= 2'h0;
            input_port_mode <= 3'h0;
        end else begin
            output_port_mode <= {ctl_q[bulk_port_pkg::OMODE_MSB_BIT],
                                 ctl_q[bulk_port_pkg::OMODE_LSB_BIT]};
            input_port_mode <= imode;
        end
    end

    // ------------------------------------------------------------
    // Direction control
    // ------------------------------------------------------------
    logic one_way;
    logic read_ok;
    logic write_ok;
    logic out_rst;
    logic in_rst;

    assign one_way = mode_a & ctl_q[bulk_port_pkg::ONE_WAY_BIT];
    assign write_ok = ~one_way | ctl_q[bulk_port_pkg::WR_ONLY_BIT];
    assign read_ok = ~(one_way & ctl_q[bulk_port_pkg::WR_ONLY_BIT]);
    assign out_rst = ctl_q[bulk_port_pkg::OUT_RST_BIT];
    assign in_rst = ctl_q[bulk_port_pkg::IN_RST_BIT];

    // ------------------------------------------------------------
    // Output side
    // ------------------------------------------------------------
    logic in_pkt_q;
    logic rx_take;
    logic [3:0] rx_keep;
    logic avail_lvl;

    assign rx_take = rx_valid & read_ok;
    assign rx_keep = keep(rx_last, rx_bytes);
    assign avail_lvl = read_ok & (avail_raw | (mode_a & ctl_q[bulk_port_pkg::HOLD_BIT] &
                                               (in_pkt_q | rx_take)));

    // Packet tracking for the held available indication
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_pkt_q <= 1'b0;
        end else if (out_rst) begin
            in_pkt_q <= 1'b0;
        end else if (rx_take) begin
            in_pkt_q <= ~rx_last;
        end
    end

    // Quadlet to the port: pad zeroed, lanes trimmed unless padding passes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_data <= 32'h00000000;
            out_byte_en <= 4'h0;
        end else if (out_rst) begin
            out_data <= 32'h00000000;
            out_byte_en <= 4'h0;
        end else if (rx_take) begin
            out_data <= order(rx_data & lanes(rx_keep), le_of(ctl_q, rx_stream));
            out_byte_en <= ctl_q[bulk_port_pkg::PASS_PAD_BIT] ? 4'hF
                           : (le_of(ctl_q, rx_stream)
                              ? {rx_keep[0], rx_keep[1], rx_keep[2], rx_keep[3]}
                              : rx_keep);
        end
    end

    // Bus drive and output pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_data_oe <= 1'b0;
            output_available <= 1'b0;
            output_enable_pin <= 1'b0;
        end else if (out_rst) begin
            out_data_oe <= 1'b0;
            output_available <= ~ctl_q[bulk_port_pkg::AVAIL_POL_BIT];
            output_enable_pin <= ~ctl_q[bulk_port_pkg::OEN_POL_BIT];
        end else begin
            out_data_oe <= rx_take & ~ctl_q[bulk_port_pkg::FLOAT_BIT];
            output_available <= avail_lvl ~^ ctl_q[bulk_port_pkg::AVAIL_POL_BIT];
            output_enable_pin <= rx_take ~^ ctl_q[bulk_port_pkg::OEN_POL_BIT];
        end
    end

    // ------------------------------------------------------------
    // Input side
    // ------------------------------------------------------------
    logic in_take;
    logic [3:0] in_keep;

    assign in_take = write_ok &
                     (input_enable_pin == ctl_q[bulk_port_pkg::IEN_POL_BIT]);
    assign in_keep = keep(in_last, in_bytes);

    // Quadlets from the port; short final quadlet filled with zeros
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data <= 32'h00000000;
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
        end else if (in_rst) begin
            tx_data <= 32'h00000000;
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
        end else begin
            tx_valid <= in_take;
            tx_last <= in_take & in_last;
            if (in_take) begin
                tx_data <= order(in_data, le_of(ctl_q, in_stream)) & lanes(in_keep);
            end
        end
    end

    // Input busy and flag pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_busy <= 1'b0;
            packet_enable_flag <= 1'b0;
            packet_error_flag <= 1'b0;
            valid_flag <= 1'b0;
        end else begin
            input_busy <= (busy_raw | in_rst) ~^ ctl_q[bulk_port_pkg::BUSY_POL_BIT];
            packet_enable_flag <= (mode_a | mode_b) &
                (pkt_enable_raw ~^ ctl_q[bulk_port_pkg::PEN_POL_BIT]);
            packet_error_flag <= (mode_a | mode_b) &
                (pkt_error_raw ~^ ctl_q[bulk_port_pkg::PERR_POL_BIT]);
            valid_flag <= mode_b & (valid_raw ~^ ctl_q[bulk_port_pkg::VALID_POL_BIT]);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_UNUSED_ZERO: assert property ((ctl_q & ~bulk_port_pkg::CTL_WMASK) == 32'h0)
        else $error("unused control bits not zero");
    AST_WRITE_STORES: assert property (wr_take |=> (ctl_q[28:8] ==
        ($past(pwdata[28:8]) & bulk_port_pkg::CTL_WMASK[28:8])))
        else $error("write not stored");
    AST_OUT_RST_CLEARS: assert property (ctl_q[bulk_port_pkg::OUT_RST_BIT] && !wr_take
        |=> !ctl_q[bulk_port_pkg::OUT_RST_BIT] && !out_data_oe && out_byte_en == 4'h0
            && out_data == 32'h00000000)
        else $error("output-side reset not self-clearing");
    AST_IN_RST_CLEARS: assert property (ctl_q[bulk_port_pkg::IN_RST_BIT] && !wr_take
        |=> !ctl_q[bulk_port_pkg::IN_RST_BIT] && !tx_valid)
        else $error("input-side reset not self-clearing");
    AST_FLOAT: assert property (ctl_q[bulk_port_pkg::FLOAT_BIT] |=> !out_data_oe)
        else $error("data bus driven while floated");
    AST_WRITE_ONLY: assert property (mode_a && ctl_q[bulk_port_pkg::ONE_WAY_BIT]
        && ctl_q[bulk_port_pkg::WR_ONLY_BIT] && rx_valid |=> !out_data_oe)
        else $error("read transfer in write-only mode");
    AST_ONE_WAY_READ: assert property (mode_a && ctl_q[bulk_port_pkg::ONE_WAY_BIT]
        && !ctl_q[bulk_port_pkg::WR_ONLY_BIT] |=> !tx_valid)
        else $error("write transfer on one-way read port");
    AST_HOLD_AVAIL: assert property (mode_a && ctl_q[bulk_port_pkg::HOLD_BIT] && in_pkt_q
        && read_ok && !out_rst
        |=> output_available == $past(ctl_q[bulk_port_pkg::AVAIL_POL_BIT]))
        else $error("available dropped inside packet");
    AST_VALID_FLAG: assert property (!mode_b |=> !valid_flag)
        else $error("valid flag outside mode 101");
    AST_PEN_POL: assert property ((mode_a || mode_b) |=>
        packet_enable_flag == ($past(pkt_enable_raw)
            ~^ $past(ctl_q[bulk_port_pkg::PEN_POL_BIT])))
        else $error("packet enable polarity wrong");
    AST_PERR_POL: assert property ((mode_a || mode_b) |=>
        packet_error_flag == ($past(pkt_error_raw)
            ~^ $past(ctl_q[bulk_port_pkg::PERR_POL_BIT])))
        else $error("packet error polarity wrong");
    AST_PAD_ZERO: assert property (rx_take && rx_last && rx_bytes == 2'h1 && !out_rst
        && !ctl_q[bulk_port_pkg::TS_LE_BIT] && rx_stream == bulk_port_pkg::STREAM_TS
        |=> out_data[23:0] == 24'h000000)
        else $error("pad bytes not zero");
    AST_STRIP: assert property (rx_take && rx_last && rx_bytes == 2'h2 && !out_rst
        && !ctl_q[bulk_port_pkg::PASS_PAD_BIT] && rx_stream == bulk_port_pkg::STREAM_TS
        && !ctl_q[bulk_port_pkg::TS_LE_BIT] |=> out_byte_en == 4'hC)
        else $error("padding not stripped");
    AST_OMODE_COPY: assert property (1'b1 |=>
        output_port_mode == {$past(ctl_q[bulk_port_pkg::OMODE_MSB_BIT]),
                             $past(ctl_q[bulk_port_pkg::OMODE_LSB_BIT])})
        else $error("output mode field not copied");
    AST_MODE_COPY: assert property (1'b1 |=> input_port_mode == $past(imode))
        else $error("input mode field not copied");
    AST_BUSY_POL: assert property (1'b1 |=> input_busy ==
        (($past(busy_raw) || $past(ctl_q[bulk_port_pkg::IN_RST_BIT]))
         ~^ $past(ctl_q[bulk_port_pkg::BUSY_POL_BIT])))
        else $error("input busy polarity wrong");
    AST_LE_ORDER: assert property (rx_take && !out_rst && !rx_last
        && rx_stream == bulk_port_pkg::STREAM_ISO && ctl_q[bulk_port_pkg::ISO_LE_BIT]
        |=> out_data[31:24] == $past(rx_data[7:0]))
        else $error("little-endian byte order wrong");
endmodule : bulk_data_port_control
`default_nettype wire

// ### bulk_port_partner.sv
// Model of the application logic that writes quadlets into the bulk data port
`default_nettype none
module bulk_port_partner (
    // Clock
    input wire logic pclk,
    // Active level of the input enable pin
    input wire logic enable_high,
    // Port write side
    output logic [31:0] in_data,
    output logic in_last,
    output logic [1:0] in_bytes,
    output logic [1:0] in_stream,
    output logic input_enable_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sending;
    logic [31:0] hold_data;
    // Idle values at time zero
    initial begin
        sending = 1'b0;
        hold_data = 32'h0;
        {in_data, in_last, in_bytes} = '0;
        in_stream = bulk_port_pkg::STREAM_TS;
        input_enable_pin = 1'b0;
    end
    // Enable follows a send; a released data bus toggles so stale data never looks valid
    always @(posedge pclk) begin
        in_data <= sending ? hold_data : ~in_data;
        input_enable_pin <= sending ~^ enable_high;
    end
    // Hands over one whole quadlet, a short last one with its valid byte count
    task automatic send(input logic [31:0] dat, input logic last, input logic [1:0] n);
        @(posedge pclk);
        sending <= 1'b1;
        hold_data <= dat;
        in_last <= last;
        in_bytes <= n;
        @(posedge pclk);
        sending <= 1'b0;
    endtask
endmodule // bulk_port_partner
`default_nettype wire

// ### bulk_data_port_control_tb_top.sv
// Self-checking bench for the bulk data port control register and pins
`default_nettype none
module bulk_data_port_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam logic [31:0] POL = 32'h001CF000;
    localparam logic [7:0] CTL = bulk_port_pkg::CTL_ADDR;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_valid, rx_last, avail_raw;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rx_data, out_data, in_data, tx_data, d, w;
    logic [1:0] rx_bytes, rx_stream, in_bytes, in_stream, output_port_mode;
    logic [2:0] input_port_mode;
    logic [3:0] out_byte_en;
    logic out_data_oe, in_last, input_enable_pin, tx_valid, tx_last, en_high, busy_raw;
    logic pkt_enable_raw, pkt_error_raw, valid_raw, input_busy, output_available;
    logic output_enable_pin, packet_enable_flag, packet_error_flag, valid_flag;
    logic [35:0] e;
    logic [35:0] exp_rd[$];
    logic [35:0] exp_out[$];
    logic [35:0] exp_tx[$];
    int mismatches = 0;
    int comparisons = 0;
    int seed = 28;
    bulk_data_port_control bulk_data_port_control_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_bytes(rx_bytes),
        .rx_stream(rx_stream), .avail_raw(avail_raw), .out_data(out_data),
        .out_data_oe(out_data_oe), .out_byte_en(out_byte_en), .in_data(in_data),
        .in_last(in_last), .in_bytes(in_bytes), .in_stream(in_stream),
        .input_enable_pin(input_enable_pin), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .busy_raw(busy_raw), .pkt_enable_raw(pkt_enable_raw),
        .pkt_error_raw(pkt_error_raw), .valid_raw(valid_raw), .input_busy(input_busy),
        .output_available(output_available), .output_enable_pin(output_enable_pin),
        .packet_enable_flag(packet_enable_flag), .packet_error_flag(packet_error_flag),
        .valid_flag(valid_flag), .output_port_mode(output_port_mode),
        .input_port_mode(input_port_mode));
    bulk_port_partner bulk_port_partner_inst (
        .pclk(pclk), .enable_high(en_high), .in_data(in_data), .in_last(in_last),
        .in_bytes(in_bytes), .in_stream(in_stream), .input_enable_pin(input_enable_pin));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One APB transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] wd);
        apb(1'b1, CTL, wd);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        exp_rd.push_back(36'(exp));
        apb(1'b0, a, 32'h0);
    endtask
    // One quadlet from the link side; the bus toggles once released
    task automatic rx(input logic [31:0] dat, input logic last, input logic [1:0] n,
                      input logic [1:0] s);
        @(posedge pclk);
        {rx_valid, rx_data, rx_last, rx_bytes, rx_stream} <= {1'b1, dat, last, n, s};
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data <= ~dat;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    function automatic logic [31:0] swap(input logic [31:0] v);
        swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction
    // ------------------------------------------------------------
    // Clock, monitor and watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Takes the oldest note off a queue whenever its result appears
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_rd.size() > 0 ? exp_rd.pop_front() : 'x;
            check(36'({pslverr, prdata}), e);
        end
        if (out_data_oe === 1'b1) begin
            e = exp_out.size() > 0 ? exp_out.pop_front() : 'x;
            check({out_byte_en, out_data}, e);
        end
        if (tx_valid === 1'b1) begin
            e = exp_tx.size() > 0 ? exp_tx.pop_front() : 'x;
            check(36'({tx_last, tx_data}), e);
        end
    end
    initial begin
        #100us;
        mismatches++;
        complete_run();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, rx_valid, rx_last, avail_raw, busy_raw} = '0;
        {paddr, pwdata, rx_data, rx_bytes, rx_stream, d, w} = '0;
        {pkt_enable_raw, pkt_error_raw, valid_raw} = '0;
        en_high = 1'b1;
        settle(6);
        presetn <= 1'b1;
        rd(CTL, {1'b0, POL});
        rd(8'hD4, 33'h100000000);
        for (int i = 0; i < 4; i++) begin
            w = ($random(seed) & 32'h9FFFFFFF) | 32'h00008000;
            wr(w);
            rd(CTL, {1'b0, w & 32'h9EDFFF00});
            check(36'({output_port_mode, input_port_mode}),
                  36'({w[22], w[23], w[25], w[26], w[27]}));
        end
        wr(POL | 32'h60000000);
        rd(CTL, {1'b0, POL});
        // One-way read mode refuses port writes, so the enable polarity flips safely
        wr(POL | 32'h04010000);
        d = $random(seed);
        exp_out.push_back({4'hF, d});
        rx(d, 1'b0, 2'h0, 2'h0);
        bulk_port_partner_inst.send(d, 1'b0, 2'h0);
        en_high <= 1'b0;
        wr(32'h04010000);
        settle(3);
        check(36'({input_busy, output_available, output_enable_pin, packet_enable_flag,
                   packet_error_flag, valid_flag}), 36'h3E);
        wr(32'h0A000000);
        settle(3);
        check(36'({packet_enable_flag, packet_error_flag, valid_flag}), 36'h7);
        {busy_raw, pkt_enable_raw, pkt_error_raw, valid_raw} <= 4'hF;
        settle(3);
        check(36'({input_busy, packet_enable_flag, packet_error_flag, valid_flag}), 36'h0);
        {busy_raw, pkt_enable_raw, pkt_error_raw, valid_raw} <= 4'h0;
        wr(32'h0);
        settle(2);
        check(36'({packet_enable_flag, packet_error_flag, valid_flag}), 36'h0);
        exp_tx.push_back({4'h0, d});
        bulk_port_partner_inst.send(d, 1'b0, 2'h0);
        wr(32'h04010000);
        en_high <= 1'b1;
        wr(POL | 32'h04010000);
        // Byte order per stream, the ISO select alone and the TS and ASY selects together
        for (int k = 0; k < 2; k++) begin
            w = k ? 32'h00000A00 : 32'h00000400;
            wr(POL | w);
            for (int s = 0; s < 3; s++) begin
                d = $random(seed);
                exp_out.push_back({4'hF, w[9 + s] ? swap(d) : d});
                rx(d, 1'b0, 2'h0, 2'(s));
            end
        end
        wr(POL);
        exp_out.push_back({4'h8, d & 32'hFF000000});
        rx(d, 1'b1, 2'h1, 2'h0);
        exp_out.push_back({4'hC, d & 32'hFFFF0000});
        rx(d, 1'b1, 2'h2, 2'h0);
        exp_tx.push_back({4'h1, d & 32'hFFFF0000});
        bulk_port_partner_inst.send(d, 1'b1, 2'h2);
        wr(POL | 32'h10000000);
        exp_out.push_back({4'hF, d & 32'hFF000000});
        rx(d, 1'b1, 2'h1, 2'h0);
        wr(POL | 32'h04030000);
        rx(d, 1'b0, 2'h0, 2'h0);
        exp_tx.push_back({4'h0, d});
        bulk_port_partner_inst.send(d, 1'b0, 2'h0);
        wr(POL | 32'h80000000);
        rx(d, 1'b0, 2'h0, 2'h0);
        settle(1);
        check(36'(out_data_oe), 36'h0);
        wr(POL | 32'h04000100);
        exp_out.push_back({4'hF, d});
        rx(d, 1'b0, 2'h0, 2'h0);
        settle(2);
        check(36'(output_available), 36'h1);
        exp_out.push_back({4'hF, d});
        rx(d, 1'b1, 2'h0, 2'h0);
        settle(3);
        check(36'(output_available), 36'h0);
        settle(5);
        check(36'(exp_rd.size() + exp_out.size() + exp_tx.size()), 36'h0);
        complete_run();
    end
endmodule // bulk_data_port_control_tb_top
`default_nettype wire
